// *** logic/lcdcd_map.svh ***
// register offsets, control word layout, reset values and counts
`ifndef LCDCD_MAP_SVH
`define LCDCD_MAP_SVH

// apb byte offsets
`define LCDCD_OFF_CTRL 12'h000
`define LCDCD_OFF_DDATA 12'h004
`define LCDCD_OFF_CFG 12'h008
`define LCDCD_OFF_STAT 12'h00C

// control word bit positions, first serial bit is bit 0
`define LCDCD_B_OSC 0
`define LCDCD_B_P9A 1
`define LCDCD_B_P9B 2
`define LCDCD_B_SLA 3
`define LCDCD_B_SLB 4
`define LCDCD_B_KSA 5
`define LCDCD_B_KSB 6
`define LCDCD_B_GPA 7
`define LCDCD_B_GPB 8
`define LCDCD_B_GPC 9
`define LCDCD_B_GPD 10
`define LCDCD_B_BLANK 11
`define LCDCD_CTRL_W 12

// reset values: sleep code 11, display blanked
`define LCDCD_CTRL_RST 12'h818
`define LCDCD_DDATA_RST 32'h0000_0000
`define LCDCD_CFG_RST 32'h0000_0000

// serial device address and internal oscillator divider
`define LCDCD_DEV_ADDR 8'h42
`define LCDCD_RC_DIV 10

`endif

// *** logic/lcdcd_pkg.sv ***
// types shared by the control decode block
package lcdcd_pkg;
  // serial receiver phases
  typedef enum logic [1:0] {
    RX_ADDR,
    RX_DATA,
    RX_SKIP
  } lcdcd_rx_state_type;

  // shared port-9 pin function
  typedef enum logic [1:0] {
    P9_GP_LOW,
    P9_GP_HIGH,
    P9_CLOCK,
    P9_SEGMENT
  } lcdcd_p9_mode_type;
endpackage

// *** logic/lcdcd_serial_rx.sv ***
// serial control receiver: address phase, data phase, commit at frame end
`timescale 1ns/1ps
`include "lcdcd_map.svh"
module lcdcd_serial_rx
  import lcdcd_pkg::*;
#(
  parameter int CTRL_W = `LCDCD_CTRL_W,
  parameter logic [7:0] DEV_ADDR = `LCDCD_DEV_ADDR
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic cl_in,
  input wire logic di_in,
  output logic [CTRL_W-1:0] word_out,
  output logic load_out
);
  lcdcd_rx_state_type state_reg; // receiver phase
  logic cl_prev_reg; // last serial clock level
  logic ce_prev_reg; // last enable level
  logic [7:0] addr_reg; // address shifter, lsb first
  logic [CTRL_W-1:0] data_reg; // data shifter, lsb first
  logic [4:0] cnt_reg; // data bits seen, saturating
  logic cl_rise; // serial clock rising
  logic ce_rise; // frame start
  logic ce_fall; // frame end

  assign cl_rise = cl_in & ~cl_prev_reg;
  assign ce_rise = ce_in & ~ce_prev_reg;
  assign ce_fall = ~ce_in & ce_prev_reg;

  // edge history
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cl_prev_reg <= 1'b0;
      ce_prev_reg <= 1'b0;
    end else begin
      cl_prev_reg <= cl_in;
      ce_prev_reg <= ce_in;
    end
  end

  // address shifts only while enable is low
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_reg <= 8'h00;
    end else if (!ce_in && cl_rise) begin
      addr_reg <= {di_in, addr_reg[7:1]};
    end
  end

  // phase tracking; foreign addresses are ignored to frame end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= RX_ADDR;
    end else if (ce_rise) begin
      state_reg <= (addr_reg == DEV_ADDR) ? RX_DATA : RX_SKIP;
    end else if (ce_fall) begin
      state_reg <= RX_ADDR;
    end
  end

  // data shifter and bit count
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_reg <= '0;
      cnt_reg <= 5'h00;
    end else if (ce_rise) begin
      cnt_reg <= 5'h00;
    end else if (state_reg == RX_DATA && ce_in && cl_rise) begin
      data_reg <= {di_in, data_reg[CTRL_W-1:1]};
      if (cnt_reg != 5'h1F) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  // commit only a complete addressed frame, short or long ones drop
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_out <= `LCDCD_CTRL_RST;
      load_out <= 1'b0;
    end else begin
      load_out <= 1'b0;
      if (ce_fall && state_reg == RX_DATA && cnt_reg == 5'(CTRL_W)) begin
        word_out <= data_reg;
        load_out <= 1'b1;
      end
    end
  end
endmodule

// *** logic/lcdcd_clk_div.sv ***
// clock source select, sleep gating and half-rate clock output
`timescale 1ns/1ps
`include "lcdcd_map.svh"
module lcdcd_clk_div
  import lcdcd_pkg::*;
#(
  parameter int RC_DIV = `LCDCD_RC_DIV
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ext_sel_in,
  input wire logic ext_clk_in,
  input wire logic run_in,
  output logic tick_out,
  output logic half_out
);
  logic [7:0] rc_cnt_reg; // internal oscillator stand-in
  logic ext_prev_reg; // last external clock level
  logic rc_tick; // internal oscillator edge
  logic ext_tick; // external clock rising edge

  assign rc_tick = (rc_cnt_reg == 8'(RC_DIV - 1));
  assign ext_tick = ext_clk_in & ~ext_prev_reg;

  // internal oscillator runs only when selected and awake
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rc_cnt_reg <= 8'h00;
    end else if (!run_in || ext_sel_in || rc_tick) begin
      rc_cnt_reg <= 8'h00;
    end else begin
      rc_cnt_reg <= rc_cnt_reg + 8'h01;
    end
  end

  // external clock edge detect
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk_in;
    end
  end

  // one-cycle tick of the active source, none in sleep
  assign tick_out = run_in & (ext_sel_in ? ext_tick : rc_tick);

  // toggling on each tick gives half the source rate
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      half_out <= 1'b0;
    end else if (!run_in) begin
      half_out <= 1'b0;
    end else if (tick_out) begin
      half_out <= ~half_out;
    end
  end
endmodule

// *** logic/lcdcd_top.sv ***
// control decode top: serial load, apb view and pin function decode
//
// Function
// - oscillator bit picks rc or external clock
// - port-9 code 00 low, 10 high output
// - port-9 code 01 outputs half-rate clock
// - port-9 code 11 becomes segment 77
// - sleep code 00 normal, else sleep
// - standby strobe levels follow sleep code
// - scan select frees strobe pins as segments
// - count field turns first pins general-purpose
// - gp level from every fourth or third bit
// - gp output follows its data bit
// - blank bit 0 on, 1 off
// - blanked segments still driven, off waveform
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "lcdcd_map.svh"
module lcdcd_top
  import lcdcd_pkg::*;
#(
  parameter int RC_DIV = `LCDCD_RC_DIV,
  parameter int GP_PINS = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic SER_CE_IN,
  input wire logic SER_CL_IN,
  input wire logic SER_DI_IN,
  input wire logic EXT_CLK_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic RC_OSC_EN_OUT,
  output logic PORT9_SHARED_PIN_OUT,
  output logic PORT9_IS_SEG_OUT,
  output logic [5:0] SCAN_STROBE_OUT,
  output logic STROBE_ONE_IS_SEG_OUT,
  output logic STROBE_TWO_IS_SEG_OUT,
  output logic [GP_PINS-1:0] GP_PIN_OUT,
  output logic [GP_PINS-1:0] GP_PIN_EN_OUT,
  output logic SEG_COM_RUN_OUT,
  output logic SEG_OFF_WAVE_OUT
);
  logic [`LCDCD_CTRL_W-1:0] ctrl_word; // committed control bits
  logic ctrl_load; // commit pulse
  logic [31:0] ddata_reg; // display bits d1 upward at bit 0
  logic [31:0] ddata_next; // next display bits
  logic duty_third_reg; // 1 selects 1/3 duty
  logic duty_third_next; // next duty select
  logic [15:0] load_cnt_reg; // commits seen, wraps
  logic clock_source_sel; // 1 external clock
  logic port9_func_bit_a; // port-9 code, first bit
  logic port9_func_bit_b; // port-9 code, second bit
  logic sleep_code_bit_a; // sleep code, first bit
  logic sleep_code_bit_b; // sleep code, second bit
  logic scan_pin_sel_a; // scan select, first bit
  logic scan_pin_sel_b; // scan select, second bit
  logic [3:0] gp_count; // number of gp pins
  logic display_blank_ctl; // 1 blanks segments
  logic sleeping; // any non-zero sleep code
  logic osc_tick; // active source tick
  logic osc_half; // half-rate clock
  lcdcd_p9_mode_type p9_mode; // decoded port-9 function
  logic apb_wr; // apb write access phase
  logic apb_hit; // mapped address

  // serial control receiver
  lcdcd_serial_rx #(
    .CTRL_W(`LCDCD_CTRL_W),
    .DEV_ADDR(`LCDCD_DEV_ADDR)
  ) u_rx (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(SER_CE_IN),
    .cl_in(SER_CL_IN),
    .di_in(SER_DI_IN),
    .word_out(ctrl_word),
    .load_out(ctrl_load)
  );

  // field split of the committed word, all fields change together
  assign clock_source_sel = ctrl_word[`LCDCD_B_OSC];
  assign port9_func_bit_a = ctrl_word[`LCDCD_B_P9A];
  assign port9_func_bit_b = ctrl_word[`LCDCD_B_P9B];
  assign sleep_code_bit_a = ctrl_word[`LCDCD_B_SLA];
  assign sleep_code_bit_b = ctrl_word[`LCDCD_B_SLB];
  assign scan_pin_sel_a = ctrl_word[`LCDCD_B_KSA];
  assign scan_pin_sel_b = ctrl_word[`LCDCD_B_KSB];
  // first count bit is the most significant
  assign gp_count = {ctrl_word[`LCDCD_B_GPA], ctrl_word[`LCDCD_B_GPB],
                     ctrl_word[`LCDCD_B_GPC], ctrl_word[`LCDCD_B_GPD]};
  assign display_blank_ctl = ctrl_word[`LCDCD_B_BLANK];

  // any code other than 00 is sleep
  assign sleeping = sleep_code_bit_a | sleep_code_bit_b;

  // oscillator source and half-rate output, stopped in sleep
  lcdcd_clk_div #(
    .RC_DIV(RC_DIV)
  ) u_clk (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .ext_sel_in(clock_source_sel),
    .ext_clk_in(EXT_CLK_IN),
    .run_in(~sleeping),
    .tick_out(osc_tick),
    .half_out(osc_half)
  );

  // rc network enabled only in rc mode while awake
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RC_OSC_EN_OUT <= 1'b0;
    end else begin
      RC_OSC_EN_OUT <= ~clock_source_sel & ~sleeping;
    end
  end

  // port-9 code, first bit is the low bit of the table order
  always_comb begin
    case ({port9_func_bit_b, port9_func_bit_a})
      2'b00: p9_mode = P9_GP_LOW;
      2'b01: p9_mode = P9_GP_HIGH;
      2'b10: p9_mode = P9_CLOCK;
      2'b11: p9_mode = P9_SEGMENT;
      default: p9_mode = P9_GP_LOW;
    endcase
  end

  // port-9 pin level; clock reads low in sleep, the host must not use it
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PORT9_SHARED_PIN_OUT <= 1'b0;
      PORT9_IS_SEG_OUT <= 1'b0;
    end else begin
      PORT9_IS_SEG_OUT <= (p9_mode == P9_SEGMENT);
      case (p9_mode)
        P9_GP_LOW: PORT9_SHARED_PIN_OUT <= 1'b0;
        P9_GP_HIGH: PORT9_SHARED_PIN_OUT <= 1'b1;
        P9_CLOCK: PORT9_SHARED_PIN_OUT <= osc_half;
        // segment drive comes from the waveform generator
        P9_SEGMENT: PORT9_SHARED_PIN_OUT <= 1'b0;
        default: PORT9_SHARED_PIN_OUT <= 1'b0;
      endcase
    end
  end

  // standby strobe levels from the sleep code
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SCAN_STROBE_OUT <= 6'h3F;
    end else begin
      case ({sleep_code_bit_a, sleep_code_bit_b})
        2'b01: SCAN_STROBE_OUT <= 6'h20;
        2'b10: SCAN_STROBE_OUT <= 6'h30;
        default: SCAN_STROBE_OUT <= 6'h3F;
      endcase
    end
  end

  // strobe pins released to segment use
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      STROBE_ONE_IS_SEG_OUT <= 1'b0;
      STROBE_TWO_IS_SEG_OUT <= 1'b0;
    end else begin
      STROBE_ONE_IS_SEG_OUT <= scan_pin_sel_a | scan_pin_sel_b;
      STROBE_TWO_IS_SEG_OUT <= scan_pin_sel_a;
    end
  end

  // display bit feeding gp pin idx: stride 4 or 3 from d1
  function automatic logic gp_data(input logic [31:0] dd,
                                   input logic third, input int idx);
    logic [4:0] pos;
    pos = third ? 5'(3 * idx) : 5'(4 * idx);
    return dd[pos];
  endfunction

  // one gp stage per shared pin, lowest pins converted first
  genvar gi;
  generate
    for (gi = 0; gi < GP_PINS; gi = gi + 1) begin : g_gp
      always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          GP_PIN_EN_OUT[gi] <= 1'b0;
          GP_PIN_OUT[gi] <= 1'b0;
        end else begin
          GP_PIN_EN_OUT[gi] <= (gp_count > 4'(gi));
          if (gp_count > 4'(gi)) begin
            GP_PIN_OUT[gi] <= gp_data(ddata_reg, duty_third_reg,
                                      gi);
          end else begin
            GP_PIN_OUT[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // segment and common run flag and blanking waveform select
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SEG_COM_RUN_OUT <= 1'b0;
      SEG_OFF_WAVE_OUT <= 1'b1;
    end else begin
      // sleep holds outputs low, which the run flag tells the driver
      SEG_COM_RUN_OUT <= ~sleeping;
      // blanked pins keep running with off waveforms, never float
      SEG_OFF_WAVE_OUT <= display_blank_ctl;
    end
  end

  // commit counter, lets software see serial traffic arrive
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      load_cnt_reg <= 16'h0000;
    end else if (ctrl_load) begin
      load_cnt_reg <= load_cnt_reg + 16'h0001;
    end
  end

  // apb decode, zero wait states
  assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign apb_hit = (PADDR_IN == `LCDCD_OFF_CTRL) |
                   (PADDR_IN == `LCDCD_OFF_DDATA) |
                   (PADDR_IN == `LCDCD_OFF_CFG) |
                   (PADDR_IN == `LCDCD_OFF_STAT);
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~apb_hit;

  // writable registers, next values
  always_comb begin
    ddata_next = ddata_reg;
    duty_third_next = duty_third_reg;
    if (apb_wr && PADDR_IN == `LCDCD_OFF_DDATA) begin
      ddata_next = PWDATA_IN;
    end
    if (apb_wr && PADDR_IN == `LCDCD_OFF_CFG) begin
      duty_third_next = PWDATA_IN[0];
    end
  end

  // writable register state
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ddata_reg <= `LCDCD_DDATA_RST;
      duty_third_reg <= 1'b0;
    end else begin
      ddata_reg <= ddata_next;
      duty_third_reg <= duty_third_next;
    end
  end

  // read data registered in the setup cycle, ready in the access phase
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      case (PADDR_IN)
        `LCDCD_OFF_CTRL: PRDATA_OUT <= {20'h00000, ctrl_word};
        `LCDCD_OFF_DDATA: PRDATA_OUT <= ddata_reg;
        `LCDCD_OFF_CFG: PRDATA_OUT <= {31'h00000000, duty_third_reg};
        `LCDCD_OFF_STAT: PRDATA_OUT <= {load_cnt_reg, 14'h0000,
                                        osc_half, sleeping};
        default: PRDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // checks beside the logic they guard
  a_port9_low: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    p9_mode == P9_GP_LOW |=> !PORT9_SHARED_PIN_OUT)
    else $error("port-9 not low in gp low mode");
  a_port9_high: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    p9_mode == P9_GP_HIGH |=> PORT9_SHARED_PIN_OUT)
    else $error("port-9 not high in gp high mode");
  a_half_clock: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    osc_tick && !sleeping ##1 !sleeping |-> osc_half != $past(osc_half))
    else $error("half clock missed a source tick");
  a_sleep_stops: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    sleeping |-> !osc_tick ##1 !SEG_COM_RUN_OUT)
    else $error("clock or outputs run during sleep");
  a_strobe_levels: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    {sleep_code_bit_a, sleep_code_bit_b} == 2'b01 |=>
    SCAN_STROBE_OUT == 6'h20)
    else $error("standby strobes wrong for code 01");
  a_strobe_seg: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    scan_pin_sel_a |=> STROBE_ONE_IS_SEG_OUT && STROBE_TWO_IS_SEG_OUT)
    else $error("strobe pins not released to segments");
  // enables follow the count of the cycle before, so compare with that
  a_gp_count: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    $stable(gp_count) |=> $countones(GP_PIN_EN_OUT) ==
    ((int'($past(gp_count)) > GP_PINS) ? GP_PINS : int'($past(gp_count))))
    else $error("gp pin count mismatch");
  a_gp_last: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    gp_count >= 4'h8 && duty_third_reg |=>
    GP_PIN_OUT[7] == $past(ddata_reg[21]))
    else $error("last gp pin not from its 1/3 duty bit");
  a_blank_wave: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    display_blank_ctl |=> SEG_OFF_WAVE_OUT)
    else $error("blanking not applied");
  // word and commit pulse land on one edge, so both are seen together
  a_atomic_load: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    !ctrl_load |-> $stable(ctrl_word))
    else $error("control word changed without a commit");
endmodule

// *** testbench/lcdcd_ser_host.sv ***
// serial controller model that frames an address and control bits
`timescale 1ns/1ps
module lcdcd_ser_host (
  input wire logic clk_in,
  output logic ce_out,
  output logic cl_out,
  output logic di_out
);
  // idle: frame closed, bit clock parked low
  initial begin
    ce_out = 1'b0;
    cl_out = 1'b0;
    di_out = 1'b0;
  end

  // one bit, every level held three cycles so the sampler sees it
  task automatic send_bit(input logic b);
    @(posedge clk_in);
    di_out <= b;
    repeat (3) @(posedge clk_in);
    cl_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    cl_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask

  // address lsb first with enable low, then nbits of data, lsb first
  // a wrong address or bit count is only sent when a test asks for it
  task automatic send_frame(input logic [7:0] addr, input int nbits,
                            input logic [15:0] data);
    for (int i = 0; i < 8; i++) send_bit(addr[i]);
    @(posedge clk_in);
    ce_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < nbits; i++) send_bit(data[i]);
    @(posedge clk_in);
    ce_out <= 1'b0;
    // data line no longer meaningful, so show a changed level
    di_out <= ~di_out;
    repeat (3) @(posedge clk_in);
  endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the control decode top
`timescale 1ns/1ps
`include "lcdcd_map.svh"
module tb;
  import lcdcd_pkg::*;
  logic clk, rst_b, ext_clk, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rc_en, p9_pin, p9_seg, s1_seg, s2_seg, run, off;
  logic [5:0] strobe;
  logic [7:0] gp, gp_en;
  logic ce, cl, di;
  int err_count, samples_checked, good_loads;

  // short divider keeps the rc stand-in clock quick
  lcdcd_top #(.RC_DIV(4)) u_dut (
    .REF_CLK_IN(clk), .RST_B_IN(rst_b), .SER_CE_IN(ce), .SER_CL_IN(cl),
    .SER_DI_IN(di), .EXT_CLK_IN(ext_clk), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .RC_OSC_EN_OUT(rc_en),
    .PORT9_SHARED_PIN_OUT(p9_pin), .PORT9_IS_SEG_OUT(p9_seg),
    .SCAN_STROBE_OUT(strobe), .STROBE_ONE_IS_SEG_OUT(s1_seg),
    .STROBE_TWO_IS_SEG_OUT(s2_seg), .GP_PIN_OUT(gp), .GP_PIN_EN_OUT(gp_en),
    .SEG_COM_RUN_OUT(run), .SEG_OFF_WAVE_OUT(off));
  lcdcd_ser_host u_host (.clk_in(clk), .ce_out(ce), .cl_out(cl),
    .di_out(di));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // external clock: rising edge every eight cycles
  initial begin
    ext_clk = 1'b0;
    forever begin
      repeat (4) @(posedge clk);
      ext_clk <= ~ext_clk;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // good frame, then let the commit and decode land
  task automatic load(input logic [11:0] w);
    u_host.send_frame(`LCDCD_DEV_ADDR, 12, {4'h0, w});
    good_loads++;
    repeat (6) @(posedge clk);
  endtask

  // transitions of the port-9 pin, sampled away from the edge
  task automatic count_p9(input int cyc, output int n);
    logic last;
    n = 0;
    last = p9_pin;
    repeat (cyc) begin
      @(negedge clk);
      if (p9_pin !== last) n++;
      last = p9_pin;
    end
  endtask

  task automatic t_reset;
    chk(strobe, 6'h3F);
    chk(run, 1'b0);
    chk(off, 1'b1);
    chk(rc_en, 1'b0);
    apb(1'b0, `LCDCD_OFF_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0000_0818);
    $display("test reset done");
  endtask

  task automatic t_port9;
    int n;
    for (int c = 0; c < 4; c++) begin
      load(12'(c << 1));
      chk(rc_en, 1'b1);
      chk(p9_seg, c == 3);
      if (c < 2) chk(p9_pin, c[0]);
      if (c == 2) begin
        count_p9(80, n);
        chk(n > 0, 1'b1);
      end
    end
    $display("test port9 done");
  endtask

  // eight external rises must give seven to nine pin changes
  task automatic t_ext;
    int n;
    load(12'h005);
    chk(rc_en, 1'b0);
    count_p9(64, n);
    chk(n >= 7 && n <= 9, 1'b1);
    // clock code kept while asleep: controller must not use it
    load(12'h00D);
    count_p9(64, n);
    chk(n, 32'h0);
    chk(p9_pin, 1'b0);
    $display("test external clock done");
  endtask

  task automatic t_sleep;
    logic [5:0] exp [4] = '{6'h3F, 6'h20, 6'h30, 6'h3F};
    for (int i = 0; i < 4; i++) begin
      load({7'h00, i[0], i[1], 3'h0});
      chk(strobe, exp[i]);
      chk(run, i == 0);
      chk(rc_en, i == 0);
    end
    $display("test sleep done");
  endtask

  task automatic t_scan;
    for (int i = 0; i < 4; i++) begin
      load({5'h00, i[0], i[1], 5'h00});
      chk(s1_seg, i != 0);
      chk(s2_seg, i[1]);
    end
    $display("test scan select done");
  endtask

  // count field in both duties, with boundary counts 0, 8 and 15
  task automatic t_gp;
    logic [31:0] dd;
    logic [7:0] en, lv;
    int cnt [5] = '{0, 1, 5, 8, 15};
    dd = 32'hA5C3_9617;
    apb(1'b1, `LCDCD_OFF_DDATA, dd, rd, er);
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, `LCDCD_OFF_CFG, 32'(d), rd, er);
      for (int k = 0; k < 5; k++) begin
        load({1'b0, cnt[k][0], cnt[k][1], cnt[k][2], cnt[k][3], 7'h00});
        en = cnt[k] >= 8 ? 8'hFF : 8'((1 << cnt[k]) - 1);
        for (int p = 0; p < 8; p++) lv[p] = dd[d != 0 ? 3 * p : 4 * p];
        chk(gp_en, en);
        chk(gp, en & lv);
      end
    end
    $display("test gp outputs done");
  endtask

  task automatic t_blank;
    load(12'h800);
    chk(off, 1'b1);
    chk(run, 1'b1);
    load(12'h000);
    chk(off, 1'b0);
    $display("test blank done");
  endtask

  // wrong address, short and long frames all leave the word alone
  task automatic t_refuse;
    load(12'h0A5);
    u_host.send_frame(8'h43, 12, 16'h0800);
    u_host.send_frame(`LCDCD_DEV_ADDR, 11, 16'h0800);
    u_host.send_frame(`LCDCD_DEV_ADDR, 13, 16'h0800);
    repeat (6) @(posedge clk);
    apb(1'b0, `LCDCD_OFF_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0000_00A5);
    chk(off, 1'b0);
    $display("test refused frames done");
  endtask

  // control word is read-only from the bus; unmapped place errors
  task automatic t_apb;
    apb(1'b1, `LCDCD_OFF_CTRL, 32'h0000_0FFF, rd, er);
    chk(er, 1'b0);
    apb(1'b0, `LCDCD_OFF_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0000_00A5);
    chk(er, 1'b0);
    // commit count in the upper half, awake so the sleep flag is clear
    apb(1'b0, `LCDCD_OFF_STAT, 32'h0, rd, er);
    chk(rd & 32'hFFFF_0001, {16'(good_loads), 16'h0000});
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test apb done");
  endtask

  // main sequence
  initial begin
    err_count = 0;
    samples_checked = 0;
    good_loads = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_port9();
    t_ext();
    t_sleep();
    t_scan();
    t_gp();
    t_blank();
    t_refuse();
    t_apb();
    complete_run();
  end

  // watchdog, well above the roughly 6000 cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
